// *** hw/i2sp_consts.svh ***
// Overview of operation
// (RULE1) idle: nobody pulls clock or data low
// (RULE2) data falls, clock high: start
// (RULE3) data rises, clock high: stop
// (RULE4) data changes only while clock low
// (RULE5) only the master makes start, stop
// (RULE6) master clocks both directions
// (RULE7) master sends address before data
// (RULE8) slave compares address with own
// (RULE9) address direction bit: read or write
// (RULE10) master and slave take opposite roles
// (RULE11) slave in hardware; general call ignored
// (RULE12) master sequencing driven by software commands
// (RULE13) drivers only pull low or release
// (RULE14) works at 100 Kbps
// (RULE15) fast 400 Kbps, mixes with standard
// (RULE16) software never selects serial-peripheral modes
// (RULE17) four-bit mode field selects slave modes
// (RULE18) clock release bit stretches when cleared
// (RULE19) on match, acknowledge ninth bit, follow direction
`ifndef I2SP_CONSTS_SVH
`define I2SP_CONSTS_SVH

// ----------------------------------------
// port control register
// ----------------------------------------
`define I2SP_CTRL_RESET      8'h00
`define I2SP_CTRL_MODE_LSB   0
`define I2SP_CTRL_RELEASE    4
`define I2SP_CTRL_ENABLE     5
`define I2SP_MODE_SLV7       4'h6
`define I2SP_MODE_SLV10      4'h7
`define I2SP_MODE_MASTER     4'hb
`define I2SP_MODE_SLV7_IRQ   4'he
`define I2SP_MODE_SLV10_IRQ  4'hf
`define I2SP_TEN_PREFIX      5'h1e

// ----------------------------------------
// controller register map
// ----------------------------------------
`define I2SP_REG_CMD         5'h00
`define I2SP_REG_STAT        5'h04
`define I2SP_REG_IRQ_STAT    5'h08
`define I2SP_REG_IRQ_CLR     5'h0c
`define I2SP_REG_IRQ_EN      5'h10
`define I2SP_OP_START        3'h1
`define I2SP_OP_STOP         3'h2
`define I2SP_OP_WRITE        3'h3
`define I2SP_OP_READ         3'h4
`define I2SP_IRQ_DONE        0
`define I2SP_IRQ_NACK        1
`define I2SP_AXI_OKAY        2'h0
`define I2SP_AXI_SLVERR      2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define I2SP_ACLK_MHZ        250
`define I2SP_RATE_STD_KHZ    100
`define I2SP_RATE_FAST_KHZ   400
`define I2SP_QTR_CYC_STD     ((`I2SP_ACLK_MHZ * 1000) / (4 * `I2SP_RATE_STD_KHZ))
`define I2SP_QTR_CYC_FAST    ((`I2SP_ACLK_MHZ * 1000) / (4 * `I2SP_RATE_FAST_KHZ))

`endif

// *** hw/i2sp_pkg.sv ***
package i2sp_pkg;
	typedef enum logic [2:0] {
		I2SP_S_IDLE,
		I2SP_S_ADDR,
		I2SP_S_ACK_ADDR,
		I2SP_S_RX,
		I2SP_S_ACK_RX,
		I2SP_S_TX,
		I2SP_S_MACK
	} i2sp_slv_state_e;

	typedef enum logic [1:0] {
		I2SP_M_IDLE,
		I2SP_M_RUN
	} i2sp_mst_state_e;

	typedef logic [7:0] i2sp_byte_t;
endpackage

// *** hw/i2sp_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface i2sp_bus_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_scl_o;
	logic s_scl_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// wired-and with pull-ups: any enabled low driver wins
	assign scl = !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o));
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

	modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
	modport slave  (output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// *** hw/i2sp_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2sp_consts.svh"
module i2sp_slave (
	input  wire logic           aclk,
	input  wire logic           aresetn,
	i2sp_bus_if.slave           bus,
	input  wire logic           ctrl_wr,
	input  wire i2sp_pkg::i2sp_byte_t ctrl_wdata,
	output logic [7:0]          serial_port_control,
	input  wire logic [9:0]     own_addr,
	input  wire logic           tx_load,
	input  wire i2sp_pkg::i2sp_byte_t tx_data,
	output logic [7:0]          rx_data,
	output logic                rx_valid,
	output logic                addr_hit,
	output logic                read_active,
	output logic                start_evt,
	output logic                stop_evt
);
	import i2sp_pkg::*;

	// ----------------------------------------
	// line synchronisers and edge detection
	// ----------------------------------------
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], bus.scl};
			sda_q <= {sda_q[1:0], bus.sda};
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise  = scl_q[1] && !scl_q[2];
	assign scl_fall  = !scl_q[1] && scl_q[2];
	assign start_det = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1]; // [RULE2]
	assign stop_det  = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1]; // [RULE3]

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic [3:0] mode;
	logic       port_enable;
	logic       clock_release;
	logic       stretch_req;
	logic       slave_on;
	logic       ten_bit;
	assign mode        = serial_port_control[`I2SP_CTRL_MODE_LSB +: 4];
	assign port_enable = serial_port_control[`I2SP_CTRL_ENABLE];
	assign clock_release = serial_port_control[`I2SP_CTRL_RELEASE];
	// master mode leaves the slave idle; reserved codes do nothing
	assign slave_on = port_enable && (mode == `I2SP_MODE_SLV7 || mode == `I2SP_MODE_SLV10 ||
		mode == `I2SP_MODE_SLV7_IRQ || mode == `I2SP_MODE_SLV10_IRQ); // [RULE17] [RULE16]
	assign ten_bit = (mode == `I2SP_MODE_SLV10) || (mode == `I2SP_MODE_SLV10_IRQ);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_port_control <= `I2SP_CTRL_RESET;
		end else if (ctrl_wr) begin
			// software write wins over the hardware stretch request
			serial_port_control <= {2'b00, ctrl_wdata[5:0]};
		end else if (stretch_req) begin
			serial_port_control[`I2SP_CTRL_RELEASE] <= 1'b0; // [RULE18]
		end
	end

	i2sp_byte_t tx_buf;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_buf <= 8'h00;
		end else if (tx_load) begin
			tx_buf <= tx_data;
		end
	end

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	i2sp_slv_state_e state;
	logic [3:0]      bit_cnt;
	i2sp_byte_t      shreg;
	logic            ten_hit;
	logic            mack_nack;
	logic            is_prefix;
	logic            match7;
	assign is_prefix = shreg[7:3] == `I2SP_TEN_PREFIX;
	// address zero is general call: never matched
	assign match7 = (shreg[7:1] == own_addr[6:0]) && (shreg[7:1] != 7'h00); // [RULE8] [RULE11]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state       <= I2SP_S_IDLE;
			bit_cnt     <= 4'h0;
			shreg       <= 8'h00;
			ten_hit     <= 1'b0;
			mack_nack   <= 1'b0;
			read_active <= 1'b0;
			stretch_req <= 1'b0;
			rx_data     <= 8'h00;
			rx_valid    <= 1'b0;
			addr_hit    <= 1'b0;
			bus.s_sda_oe <= 1'b0;
		end else begin
			rx_valid    <= 1'b0;
			addr_hit    <= 1'b0;
			stretch_req <= 1'b0;
			if (!slave_on || stop_det) begin
				state        <= I2SP_S_IDLE; // [RULE3]
				ten_hit      <= 1'b0;
				read_active  <= 1'b0;
				bus.s_sda_oe <= 1'b0; // [RULE1]
			end else if (start_det) begin
				// a repeated start keeps the 10-bit match for the read header
				state        <= I2SP_S_ADDR; // [RULE2] [RULE7]
				bit_cnt      <= 4'h0;
				read_active  <= 1'b0;
				bus.s_sda_oe <= 1'b0;
			end else begin
				case (state)
				I2SP_S_IDLE: begin
					bus.s_sda_oe <= 1'b0;
				end
				I2SP_S_ADDR, I2SP_S_RX: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_q[1]};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (state == I2SP_S_RX) begin
							rx_data      <= shreg;
							rx_valid     <= 1'b1;
							state        <= I2SP_S_ACK_RX;
							bus.s_sda_oe <= 1'b1; // [RULE10]
						end else if (!ten_bit && match7) begin
							read_active  <= shreg[0]; // [RULE9]
							addr_hit     <= 1'b1;
							state        <= I2SP_S_ACK_ADDR;
							bus.s_sda_oe <= 1'b1; // [RULE19]
						end else if (ten_bit && ten_hit && !read_active &&
							shreg == own_addr[7:0]) begin
							// second 10-bit byte arrives in the address state
							addr_hit     <= 1'b1;
							state        <= I2SP_S_ACK_ADDR;
							bus.s_sda_oe <= 1'b1;
							read_active  <= 1'b0;
						end else if (ten_bit && is_prefix && shreg[2:1] == own_addr[9:8] &&
							(!shreg[0] || ten_hit)) begin
							read_active  <= shreg[0]; // [RULE9]
							if (shreg[0]) begin
								addr_hit <= 1'b1;
							end
							ten_hit      <= !shreg[0] ? 1'b0 : 1'b1;
							state        <= I2SP_S_ACK_ADDR;
							bus.s_sda_oe <= 1'b1; // [RULE19]
						end else begin
							state <= I2SP_S_IDLE;
						end
					end
				end
				I2SP_S_ACK_ADDR: begin
					if (scl_fall) begin
						bus.s_sda_oe <= 1'b0;
						if (ten_bit && !ten_hit && !read_active && shreg[7:3] == `I2SP_TEN_PREFIX) begin
							ten_hit <= 1'b1;
							state   <= I2SP_S_ADDR;
						end else if (read_active) begin
							state       <= I2SP_S_TX;
							shreg       <= tx_buf;
							stretch_req <= 1'b1; // [RULE18]
						end else begin
							state <= I2SP_S_RX;
						end
					end
				end
				I2SP_S_ACK_RX: begin
					if (scl_fall) begin
						bus.s_sda_oe <= 1'b0;
						state        <= I2SP_S_RX;
					end
				end
				I2SP_S_TX: begin
					if (bit_cnt == 4'h0 && !clock_release) begin
						// clock is held low, so data may follow late loads
						shreg        <= tx_buf;
						bus.s_sda_oe <= !tx_buf[7]; // [RULE4]
					end else if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							state        <= I2SP_S_MACK;
							bus.s_sda_oe <= 1'b0;
						end else begin
							shreg        <= {shreg[6:0], 1'b0};
							bus.s_sda_oe <= !shreg[6]; // [RULE4]
						end
					end else if (bit_cnt == 4'h0) begin
						bus.s_sda_oe <= !shreg[7];
					end
				end
				I2SP_S_MACK: begin
					if (scl_rise) begin
						mack_nack <= sda_q[1];
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (mack_nack) begin
							state       <= I2SP_S_IDLE;
							read_active <= 1'b0;
						end else begin
							state       <= I2SP_S_TX;
							shreg       <= tx_buf;
							stretch_req <= 1'b1;
						end
					end
				end
				default: begin
					state <= I2SP_S_IDLE;
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// clock stretch and open-drain outputs
	// ----------------------------------------
	// pull only once the master has already taken the line low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus.s_scl_oe <= 1'b0;
			bus.s_scl_o  <= 1'b0;
			bus.s_sda_o  <= 1'b0;
		end else begin
			bus.s_scl_oe <= slave_on && state == I2SP_S_TX && !clock_release &&
				(!scl_q[1] || bus.s_scl_oe); // [RULE18] [RULE13]
			bus.s_scl_o  <= 1'b0; // [RULE13]
			bus.s_sda_o  <= 1'b0;
		end
	end

	// ----------------------------------------
	// start and stop events
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_evt <= 1'b0;
			stop_evt  <= 1'b0;
		end else begin
			start_evt <= slave_on && mode[3] && mode[2] && start_det; // [RULE17]
			stop_evt  <= slave_on && mode[3] && mode[2] && stop_det;
		end
	end
endmodule // i2sp_slave
`default_nettype wire

// *** hw/i2sp_master.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2sp_consts.svh"
module i2sp_master #(
	parameter int QTR_CYC = `I2SP_QTR_CYC_STD
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	i2sp_bus_if.master       bus,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	import i2sp_pkg::*;

	// ----------------------------------------
	// line sync and quarter-bit divider
	// ----------------------------------------
	logic [1:0] scl_q;
	logic [1:0] sda_q;
	logic [15:0] div_cnt;
	logic        tick;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 2'h3;
			sda_q <= 2'h3;
		end else begin
			scl_q <= {scl_q[0], bus.scl};
			sda_q <= {sda_q[0], bus.sda};
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || div_cnt == 16'(QTR_CYC - 1)) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end
	assign tick = div_cnt == 16'(QTR_CYC - 1); // [RULE14] [RULE15]

	// ----------------------------------------
	// register file over axi4-lite
	// ----------------------------------------
	logic       aw_got;
	logic       w_got;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic       wr_do;
	logic       cmd_go;
	logic [2:0] cmd_op;
	i2sp_byte_t cmd_byte;
	logic       cmd_nack;
	logic [1:0] irq_stat;
	logic [1:0] irq_en;
	logic [1:0] irq_set;
	logic       busy;
	logic       last_nack;
	i2sp_byte_t rx_byte;
	assign wr_do = aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got  <= 1'b0;
			aw_addr <= 5'h00;
			w_data  <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `I2SP_AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got  <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_do) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == 5'(`I2SP_REG_CMD) || aw_addr == 5'(`I2SP_REG_IRQ_CLR) ||
					aw_addr == `I2SP_REG_IRQ_EN) ? `I2SP_AXI_OKAY : `I2SP_AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// commands while busy are dropped
	assign cmd_go = wr_do && aw_addr == 5'(`I2SP_REG_CMD) && !busy; // [RULE12]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_op   <= 3'h0;
			cmd_byte <= 8'h00;
			cmd_nack <= 1'b0;
			irq_en   <= 2'h0;
		end else if (wr_do) begin
			if (cmd_go) begin
				cmd_op   <= w_data[2:0];
				cmd_nack <= w_data[4];
				cmd_byte <= w_data[15:8];
			end
			if (aw_addr == `I2SP_REG_IRQ_EN) begin
				irq_en <= w_data[1:0];
			end
		end
	end

	// set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= 2'h0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~((wr_do && aw_addr == 5'(`I2SP_REG_IRQ_CLR)) ? w_data[1:0] : 2'h0))
				| irq_set;
			irq      <= |(irq_stat & irq_en);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `I2SP_AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `I2SP_AXI_OKAY;
				case (s_axi_araddr)
				5'(`I2SP_REG_STAT):     s_axi_rdata <= {16'h0000, rx_byte, 6'h00, last_nack, busy};
				5'(`I2SP_REG_IRQ_STAT): s_axi_rdata <= {30'h0000_0000, irq_stat};
				`I2SP_REG_IRQ_EN:       s_axi_rdata <= {30'h0000_0000, irq_en};
				5'(`I2SP_REG_CMD),
				5'(`I2SP_REG_IRQ_CLR):  s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `I2SP_AXI_SLVERR;
				end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// bus sequencer: four quarter phases per step
	// ----------------------------------------
	i2sp_mst_state_e state;
	logic [1:0] phase;
	logic [3:0] bit_idx;
	i2sp_byte_t shreg;
	logic       last_bit;
	assign busy = state == I2SP_M_RUN;
	assign last_bit = bit_idx == 4'h8;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= I2SP_M_IDLE;
			phase     <= 2'h0;
			bit_idx   <= 4'h0;
			shreg     <= 8'h00;
			rx_byte   <= 8'h00;
			last_nack <= 1'b0;
			irq_set   <= 2'h0;
			bus.m_scl_oe <= 1'b0; // [RULE1]
			bus.m_sda_oe <= 1'b0;
			bus.m_scl_o  <= 1'b0;
			bus.m_sda_o  <= 1'b0;
		end else begin
			irq_set     <= 2'h0;
			bus.m_scl_o <= 1'b0; // [RULE13]
			bus.m_sda_o <= 1'b0;
			case (state)
			I2SP_M_IDLE: begin
				if (cmd_go) begin
					state   <= I2SP_M_RUN;
					phase   <= 2'h0;
					bit_idx <= 4'h0;
					shreg   <= w_data[15:8];
				end
			end
			I2SP_M_RUN: begin
				// after release, a stretched clock holds phase 2 until the line is high
				if (tick && !(phase == 2'h2 && !scl_q[1])) begin
					phase <= phase + 2'h1;
					case (cmd_op)
					`I2SP_OP_START: begin
						case (phase)
						2'h0: bus.m_sda_oe <= 1'b0;
						2'h1: bus.m_scl_oe <= 1'b0;
						2'h2: bus.m_sda_oe <= 1'b1; // [RULE2] [RULE5]
						default: bus.m_scl_oe <= 1'b1;
						endcase
					end
					`I2SP_OP_STOP: begin
						case (phase)
						2'h0: bus.m_sda_oe <= 1'b1;
						2'h1: bus.m_scl_oe <= 1'b0;
						2'h2: bus.m_sda_oe <= 1'b0; // [RULE3] [RULE5]
						default: bus.m_sda_oe <= 1'b0;
						endcase
					end
					default: begin
						case (phase)
						2'h0: begin
							if (cmd_op == `I2SP_OP_WRITE) begin
								bus.m_sda_oe <= !last_bit && !shreg[7]; // [RULE4]
							end else begin
								bus.m_sda_oe <= last_bit && !cmd_nack; // [RULE10]
							end
						end
						2'h1: bus.m_scl_oe <= 1'b0; // [RULE6]
						2'h2: begin
							if (last_bit) begin
								last_nack <= sda_q[1];
							end else begin
								shreg <= {shreg[6:0], sda_q[1]};
							end
						end
						default: bus.m_scl_oe <= 1'b1;
						endcase
					end
					endcase
					if (phase == 2'h3) begin
						bit_idx <= bit_idx + 4'h1;
						if (cmd_op != `I2SP_OP_WRITE && cmd_op != `I2SP_OP_READ || last_bit) begin
							state   <= I2SP_M_IDLE;
							irq_set <= {cmd_op == `I2SP_OP_WRITE && last_nack, 1'b1};
							if (cmd_op == `I2SP_OP_READ) begin
								rx_byte <= shreg;
							end
						end
					end
				end
			end
			default: state <= I2SP_M_IDLE;
			endcase
		end
	end
endmodule // i2sp_master
`default_nettype wire

// *** dv/i2sp_bus_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2sp_bus_monitor #(
	parameter int QTR_CYC = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_scl_o,
	input wire logic s_scl_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ----------------------------------------
	// line event helpers
	// ----------------------------------------
	logic        scl_q;
	logic        sda_q;
	logic        in_xfer;
	logic [3:0]  rise_cnt;
	logic [7:0]  addr_sh;
	logic [15:0] hi_cnt;
	wire logic   start_c = scl && scl_q && sda_q && !sda;
	wire logic   stop_c  = scl && scl_q && !sda_q && sda;
	wire logic   rise_c  = scl && !scl_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	always_ff @(posedge aclk) begin
		scl_q <= !aresetn || scl;
		sda_q <= !aresetn || sda;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || stop_c)
			in_xfer <= 1'b0;
		else if (start_c)
			in_xfer <= 1'b1;
	end

	// counts rises since start so the address byte and its ninth bit are known
	always_ff @(posedge aclk) begin
		if (!aresetn || start_c) begin
			rise_cnt <= 4'h0;
			addr_sh  <= 8'h00;
		end else if (rise_c) begin
			if (rise_cnt != 4'hf)
				rise_cnt <= rise_cnt + 4'h1;
			if (rise_cnt < 4'h8)
				addr_sh <= {addr_sh[6:0], sda};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !scl)
			hi_cnt <= 16'h0000;
		else if (hi_cnt != 16'hffff)
			hi_cnt <= hi_cnt + 16'h0001;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_OPEN_DRAIN: assert property (!(m_scl_o || m_sda_o || s_scl_o || s_sda_o))
		else $error("a line driver drives high");
	AST_IDLE_SLAVE: assert property (!in_xfer |-> !s_sda_oe && !s_scl_oe)
		else $error("slave pulls a line outside a transfer");
	AST_IDLE_MASTER: assert property (!in_xfer && !start_c |-> !m_sda_oe && !m_scl_oe)
		else $error("master pulls a line outside a transfer");
	AST_SLAVE_SDA_LOW: assert property ($changed(s_sda_oe) |-> !scl)
		else $error("slave changes data while clock high");
	AST_STRETCH: assert property ($rose(s_scl_oe) |-> !scl_q && m_scl_oe)
		else $error("slave stretch starts while clock high");
	AST_ROLES: assert property (m_sda_oe && s_sda_oe |-> !scl)
		else $error("both ends drive data while clock high");
	AST_ADDR_QUIET: assert property (in_xfer && rise_c && rise_cnt < 4'h8 |-> !s_sda_oe)
		else $error("slave drives data during address byte");
	AST_NO_GCALL: assert property (in_xfer && rise_c && rise_cnt == 4'h8 && addr_sh == 8'h00 |-> sda)
		else $error("general call acknowledged");
	AST_SCL_HIGH_MIN: assert property (in_xfer && scl_q && !scl |-> hi_cnt >= QTR_CYC)
		else $error("clock high phase too short");

	cover property (start_c);
	cover property (stop_c);
	cover property (rise_c && rise_cnt == 4'h8 && !sda);
	cover property ($rose(s_scl_oe));
endmodule // i2sp_bus_monitor
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2sp_consts.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
	localparam int QTR = 20;
	localparam int LIMIT = 60000;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic        ctrl_wr = 1'b0, tx_load = 1'b0;
	logic [7:0]  ctrl_wdata = 8'h00, tx_data = 8'h00, serial_port_control, rx_data, rx_last;
	logic [9:0]  own_addr = 10'h000;
	logic        rx_valid, addr_hit, read_active, start_evt, stop_evt;
	int          error_cnt = 0, cmp_count = 0, cyc = 0, rx_n = 0, hit_n = 0, st_n = 0, sp_n = 0;
	logic [3:0]  modes [6] = '{`I2SP_MODE_SLV7, `I2SP_MODE_SLV10, `I2SP_MODE_MASTER, `I2SP_MODE_SLV7_IRQ,
		`I2SP_MODE_SLV10_IRQ, 4'h0};

	i2sp_bus_if bus_if ();
	i2sp_master #(.QTR_CYC(QTR)) i2sp_master_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));
	i2sp_slave i2sp_slave_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .serial_port_control(serial_port_control), .own_addr(own_addr),
		.tx_load(tx_load), .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid), .addr_hit(addr_hit),
		.read_active(read_active), .start_evt(start_evt), .stop_evt(stop_evt));
	i2sp_bus_monitor #(.QTR_CYC(QTR)) i2sp_bus_monitor_inst (.aclk(aclk), .aresetn(aresetn),
		.m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o),
		.m_sda_oe(bus_if.m_sda_oe), .s_scl_o(bus_if.s_scl_o), .s_scl_oe(bus_if.s_scl_oe),
		.s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	always #2 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc++;
		rx_n += (rx_valid === 1'b1);
		rx_last = (rx_valid === 1'b1) ? rx_data : rx_last;
		hit_n += (addr_hit === 1'b1);
		st_n += (start_evt === 1'b1);
		sp_n += (stop_evt === 1'b1);
		if (cyc == LIMIT) begin
			error_cnt++;
			results();
		end
	end

	task automatic results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// address and data may be taken in either order
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic cfg(input logic [7:0] v);
		@(posedge aclk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= v;
		@(posedge aclk);
		ctrl_wr <= 1'b0;
		@(posedge aclk);
	endtask

	// waits for done, checks masking and clearing, returns status word
	task automatic op(input logic [31:0] c, output logic [31:0] s);
		logic [1:0] r;
		wr(`I2SP_REG_CMD, c, `I2SP_AXI_OKAY);
		while (irq !== 1'b1) @(posedge aclk);
		wr(`I2SP_REG_IRQ_EN, 32'h0000_0000, `I2SP_AXI_OKAY);
		rd(`I2SP_REG_IRQ_STAT, s, r);
		`CHK("irq_masked", 1'b0, irq)
		`CHK("irq_done", 1'b1, s[`I2SP_IRQ_DONE])
		wr(`I2SP_REG_IRQ_CLR, 32'h0000_0003, `I2SP_AXI_OKAY);
		wr(`I2SP_REG_IRQ_EN, 32'h0000_0001, `I2SP_AXI_OKAY);
		rd(`I2SP_REG_STAT, s, r);
		`CHK("irq_clr", 1'b0, irq)
	endtask

	initial begin
		logic [31:0] s;
		logic [1:0]  r;
		logic [7:0]  ab, db;
		logic        ack, ten;
		int          h0, n0, st0, sp0;
		void'($urandom(32'he5dd_9baf));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK("ctrl_rst", 8'h00, serial_port_control)
		`CHK("scl_idle", 1'b1, bus_if.scl)
		`CHK("sda_idle", 1'b1, bus_if.sda)
		rd(5'h14, s, r);
		`CHK("unmapped", `I2SP_AXI_SLVERR, r)
		wr(5'h18, 32'h0000_0001, `I2SP_AXI_SLVERR);
		wr(`I2SP_REG_IRQ_EN, 32'h0000_0001, `I2SP_AXI_OKAY);
		rd(`I2SP_REG_IRQ_EN, s, r);
		`CHK("irq_en", 32'h0000_0001, s)
		own_addr <= {3'($urandom), 7'($urandom_range(1, 119))};
		foreach (modes[i]) begin
			cfg({4'b1111, modes[i]});
			`CHK("ctrl", {4'b0011, modes[i]}, serial_port_control)
			ten = (modes[i] == `I2SP_MODE_SLV10) || (modes[i] == `I2SP_MODE_SLV10_IRQ);
			ack = ten || modes[i] == `I2SP_MODE_SLV7 || modes[i] == `I2SP_MODE_SLV7_IRQ;
			ab = ten ? {`I2SP_TEN_PREFIX, own_addr[9:8], 1'b0} : {own_addr[6:0], 1'b0};
			db = 8'($urandom);
			{h0, n0, st0, sp0} = {hit_n, rx_n, st_n, sp_n};
			op(`I2SP_OP_START, s);
			op({16'h0000, ab, 8'h03}, s);
			`CHK("addr_nack", !ack, s[1])
			if (ten) begin
				op({16'h0000, own_addr[7:0], 8'h03}, s);
				`CHK("addr10_nack", 1'b0, s[1])
			end
			`CHK("addr_hit", ack ? h0 + 1 : h0, hit_n)
			op({16'h0000, db, 8'h03}, s);
			`CHK("data_nack", !ack, s[1])
			`CHK("rx_cnt", ack ? n0 + 1 : n0, rx_n)
			`CHK("rx_data", ack ? db : rx_last, rx_last)
			op(`I2SP_OP_STOP, s);
			`CHK("start_evt", modes[i][3:1] == 3'b111 ? st0 + 1 : st0, st_n)
			`CHK("stop_evt", modes[i][3:1] == 3'b111 ? sp0 + 1 : sp0, sp_n)
		end
		cfg(8'h36);
		for (int k = 0; k < 2; k++) begin
			op(`I2SP_OP_START, s);
			op({16'h0000, (k == 0) ? 7'h00 : own_addr[6:0] ^ 7'h01, 1'b0, 8'h03}, s);
			`CHK("foreign_nack", 1'b1, s[1])
			op(`I2SP_OP_STOP, s);
		end
		db = 8'($urandom);
		op(`I2SP_OP_START, s);
		op({16'h0000, own_addr[6:0], 1'b1, 8'h03}, s);
		`CHK("rd_ack", 1'b0, s[1])
		`CHK("read_active", 1'b1, read_active)
		while (serial_port_control[`I2SP_CTRL_RELEASE] !== 1'b0) @(posedge aclk);
		// the slave must keep holding the clock low itself, not lean on the idle master
		repeat (4 * QTR) @(posedge aclk);
		`CHK("stretch", 1'b1, bus_if.s_scl_oe)
		tx_data <= db;
		tx_load <= 1'b1;
		@(posedge aclk);
		tx_load <= 1'b0;
		cfg(8'h36);
		op(32'h0000_0014, s);
		`CHK("rd_byte", db, s[15:8])
		op(`I2SP_OP_STOP, s);
		`CHK("read_done", 1'b0, read_active)
		results();
	end
endmodule // testbench
`default_nettype wire
